// file: rtl/vcm_mode_control.sv
/*
 * Voice codec mode control register bank with Wishbone classic slave.
 * Holds the four control registers, produces the decoded operating state
 * and path controls for the voice datapath, and times the settle delay.
 * Assumes pins from outside the 40 MHz domain arrive asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none

module vcm_mode_control #(
  parameter int SETTLE_COUNT = vcm_pkg::SETTLE_CYC  // Cycles of the settle delay
) (
  input wire logic clk_sys,                // 40 MHz system clock
  input wire logic rst_b,                  // Async reset, active low
  input wire logic sleepPin_b,             // Power-down pin, active low
  input wire logic sleepResetPin_b,        // Power-down reset pin, active low
  input wire logic mutePin,                // External mute pin
  input wire logic test_select_input,      // Strap from host, 1 = extended mode
  input wire logic [31:0] wb_adr_i,        // Wishbone address
  input wire logic [31:0] wb_dat_i,        // Wishbone write data
  input wire logic [3:0] wb_sel_i,         // Wishbone byte selects
  input wire logic wb_we_i,                // Wishbone write enable
  input wire logic wb_cyc_i,               // Wishbone cycle
  input wire logic wb_stb_i,               // Wishbone strobe
  output logic [31:0] wb_dat_o,            // Wishbone read data
  output logic wb_ack_o,                   // Wishbone acknowledge
  output logic wb_err_o,                   // Wishbone error on unmapped address
  output var vcm_pkg::vcm_mode_t modeOut,  // Decoded operating state
  output var vcm_pkg::vcm_path_t pathOut,  // Decoded path controls
  output logic codecStateReset,            // One-cycle pulse per codec reset write, high while full reset lasts; resets both codec states
  output logic lineOutEnable,              // Line port serial out may drive
  output logic acOutEnable,                // Acoustic port serial out may drive
  output logic deviceReset                 // Internal full reset level
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sleepSync;       // Power-down pin stages
  logic [2:0] rstSync;         // Power-down reset pin stages
  logic [2:0] muteSync;        // Mute pin stages
  logic [2:0] testSync;        // Test select stages
  logic sleepPinLvl;           // Filtered power-down pin, 1 = asleep
  logic rstPinLvl;             // Filtered reset pin, 1 = reset
  logic muteLvl;               // Filtered mute
  logic testLvl;               // Filtered test select

  // Reset values equal the idle pin levels, so no false event follows reset
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sleepSync <= 3'h7;
      rstSync <= 3'h7;
      muteSync <= 3'h0;
      testSync <= 3'h0;
    end else begin
      sleepSync <= {sleepSync[1:0], sleepPin_b};
      rstSync <= {rstSync[1:0], sleepResetPin_b};
      muteSync <= {muteSync[1:0], mutePin};
      testSync <= {testSync[1:0], test_select_input};
    end
  end

  // Filtered levels hold until the last two stages agree
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sleepPinLvl <= 1'b0;
      rstPinLvl <= 1'b0;
      muteLvl <= 1'b0;
      testLvl <= 1'b0;
    end else begin
      if (sleepSync[1] == sleepSync[2]) begin
        sleepPinLvl <= ~sleepSync[2];
      end
      if (rstSync[1] == rstSync[2]) begin
        rstPinLvl <= ~rstSync[2];
      end
      if (muteSync[1] == muteSync[2]) begin
        muteLvl <= muteSync[2];
      end
      if (testSync[1] == testSync[2]) begin
        testLvl <= testSync[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  logic [7:0] regBasic;        // basic_mode_control
  logic [7:0] regCodec;        // codec_path_control
  logic [7:0] regSlot;         // pcm_slot_control
  logic [7:0] regGain;         // voice_gain_control
  logic [4:0] regIdx;          // Word index of the access
  logic upperZero;             // Address bits above the map are zero
  logic mapped;                // Access hits a register
  logic accessNew;             // First cycle of a request
  logic wrLane0;               // Write with byte lane 0 selected
  logic fullReset;             // Pin reset or self reset bit
  vcm_pkg::vcm_state_t state;  // Settle state
  logic [31:0] settleCnt;      // Settle counter

  assign regIdx = wb_adr_i[vcm_pkg::ADDR_LSB +: 5];
  assign upperZero = (wb_adr_i[31:vcm_pkg::ADDR_W] == 25'h0000000);
  assign mapped = upperZero && (regIdx <= vcm_pkg::IDX_STATUS);
  assign accessNew = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  // A write lands at the edge where the master samples ack, so the
  // register change and the acknowledge belong to the same edge
  assign wrLane0 = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign fullReset = rstPinLvl || regBasic[vcm_pkg::B_SLEEPRST];

  // One-cycle answer; ack or err drops the cycle after it was given
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= accessNew && mapped;
      wb_err_o <= accessNew && !mapped;
    end
  end

  // Read data is registered with the ack; bits above 8 read as zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h00000000;
    end else if (accessNew && !wb_we_i) begin
      case (regIdx)
        vcm_pkg::IDX_BASIC: wb_dat_o <= {24'h000000, regBasic};
        vcm_pkg::IDX_CODEC: wb_dat_o <= {24'h000000, regCodec};
        vcm_pkg::IDX_SLOT: wb_dat_o <= {24'h000000, regSlot};
        vcm_pkg::IDX_GAIN: wb_dat_o <= {24'h000000, regGain};
        vcm_pkg::IDX_STATUS: wb_dat_o <= {24'h000000, fullReset, modeOut.sleep,
                                          (state == vcm_pkg::VCM_READY), testLvl, modeOut.mode};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Basic mode register
  // ----------------------------------------------------------------
  // Pin reset clears it; the self reset bit clears all bits, itself included,
  // on the cycle after it is written, so a software reset is a single write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      regBasic <= vcm_pkg::REG_RESET;
    end else if (rstPinLvl) begin
      regBasic <= vcm_pkg::REG_RESET;
    end else if (regBasic[vcm_pkg::B_SLEEPRST]) begin
      regBasic <= vcm_pkg::REG_RESET;
    end else if (wrLane0 && regIdx == vcm_pkg::IDX_BASIC) begin
      regBasic <= wb_dat_i[7:0] & 8'h6F;  // Unused bits 7 and 4 read zero
    end
  end

  // ----------------------------------------------------------------
  // Path registers
  // ----------------------------------------------------------------
  // Full reset clears them; power-down alone keeps them
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      regCodec <= vcm_pkg::REG_RESET;
      regSlot <= vcm_pkg::REG_RESET;
      regGain <= vcm_pkg::REG_RESET;
    end else if (fullReset) begin
      regCodec <= vcm_pkg::REG_RESET;
      regSlot <= vcm_pkg::REG_RESET;
      regGain <= vcm_pkg::REG_RESET;
    end else if (wrLane0) begin
      // Codec reset bit is a strobe and never stored
      if (regIdx == vcm_pkg::IDX_CODEC) begin
        regCodec <= wb_dat_i[7:0] & 8'hBF;
      end
      if (regIdx == vcm_pkg::IDX_SLOT) begin
        regSlot <= wb_dat_i[7:0];
      end
      if (regIdx == vcm_pkg::IDX_GAIN) begin
        regGain <= wb_dat_i[7:0];
      end
    end
  end

  // Pulse both codec state resets on a write of 1, or on full reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      codecStateReset <= 1'b0;
    end else begin
      codecStateReset <= fullReset ||
                         (wrLane0 && regIdx == vcm_pkg::IDX_CODEC && wb_dat_i[vcm_pkg::B_CRST]);
    end
  end

  // ----------------------------------------------------------------
  // Settle timing
  // ----------------------------------------------------------------
  logic sleepAll;              // Combined power-down
  logic sleepPrev;             // Power-down one cycle ago
  logic restartSettle;         // Event that restarts the delay

  assign sleepAll = sleepPinLvl || regBasic[vcm_pkg::B_SLEEP];
  assign restartSettle = fullReset || (sleepAll != sleepPrev);

  // The counter is 32 bits wide so the default count of several million fits
  // Async, pin or self reset, or any power-down edge, forces initial mode for the settle time
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= vcm_pkg::VCM_SETTLE;
      settleCnt <= 32'h00000000;
      sleepPrev <= 1'b0;
    end else begin
      sleepPrev <= sleepAll;
      case (state)
        vcm_pkg::VCM_SETTLE: begin
          if (restartSettle) begin
            settleCnt <= 32'h00000000;
          end else if (settleCnt >= 32'(SETTLE_COUNT - 1)) begin
            state <= vcm_pkg::VCM_READY;
          end else begin
            settleCnt <= settleCnt + 32'h00000001;
          end
        end
        vcm_pkg::VCM_READY: begin
          if (restartSettle) begin
            state <= vcm_pkg::VCM_SETTLE;
            settleCnt <= 32'h00000000;
          end
        end
        default: state <= vcm_pkg::VCM_SETTLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic [3:0] modeReq;         // Mode the register asks for
  logic [3:0] modeEff;         // Mode in force

  assign modeReq = regBasic[vcm_pkg::F_MODE_HI:vcm_pkg::F_MODE_LO];
  // Reserved codes and the settle window both fall back to initial mode
  // A mismatched test select strap is the host's fault; the mode follows the register
  assign modeEff = (state != vcm_pkg::VCM_READY || sleepAll) ? vcm_pkg::MODE_INITIAL :
                   (modeReq == vcm_pkg::MODE_NORMAL || modeReq == vcm_pkg::MODE_EXTEC) ?
                   modeReq : vcm_pkg::MODE_INITIAL;

  // Mode outputs registered
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      modeOut <= '0;
      deviceReset <= 1'b1;
    end else begin
      deviceReset <= fullReset;
      modeOut.mode <= modeEff;
      modeOut.sleep <= sleepAll;
      modeOut.pcmIdleAll <= (modeEff == vcm_pkg::MODE_INITIAL);
      modeOut.memWriteOk <= (modeEff == vcm_pkg::MODE_INITIAL);
      modeOut.toneDetect <= (modeEff == vcm_pkg::MODE_NORMAL) ||
                            (modeEff == vcm_pkg::MODE_EXTEC);
      modeOut.ansDetect <= (modeEff == vcm_pkg::MODE_EXTEC);
      modeOut.longEcho <= (modeEff == vcm_pkg::MODE_EXTEC);
      modeOut.voiceCodecOn <= (modeEff == vcm_pkg::MODE_NORMAL);
    end
  end

  // ----------------------------------------------------------------
  // Path decode
  // ----------------------------------------------------------------
  logic [2:0] lineSel;         // line_port_slot
  logic [2:0] acSel;           // acoustic_port_slot
  logic attOn;                 // Attenuation in force

  assign lineSel = regSlot[vcm_pkg::F_LN_HI:vcm_pkg::F_LN_LO];
  assign acSel = regSlot[vcm_pkg::F_AC_HI:vcm_pkg::F_AC_LO];
  assign attOn = regCodec[vcm_pkg::B_RXATT] && !muteLvl;

  // Output enables follow the slot field alone; the serial logic picks the slot
  // Path outputs registered
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pathOut <= '0;
      lineOutEnable <= 1'b0;
      acOutEnable <= 1'b0;
    end else begin
      pathOut.codecAdpcm32 <= !regCodec[vcm_pkg::B_ALGO];
      pathOut.codecSlot2 <= regCodec[vcm_pkg::B_CSLOT];
      pathOut.txSilence <= regCodec[vcm_pkg::B_TXSIL];
      pathOut.rxAtten <= attOn ? regCodec[vcm_pkg::F_ATT_HI:vcm_pkg::F_ATT_LO] : vcm_pkg::ATT_THRU;
      pathOut.rxMuteFull <= attOn && (regCodec[vcm_pkg::F_ATT_HI:vcm_pkg::F_ATT_LO] == vcm_pkg::ATT_MUTE);
      pathOut.voiceOutIdle <= regSlot[vcm_pkg::B_VOUT] || (modeEff == vcm_pkg::MODE_INITIAL);
      pathOut.voiceInIdle <= regSlot[vcm_pkg::B_VIN] || (modeEff == vcm_pkg::MODE_INITIAL);
      pathOut.lineSlot <= lineSel;
      pathOut.acSlot <= acSel;
      pathOut.lineIdleIn <= (lineSel == vcm_pkg::SLOT_NONE) || (modeEff == vcm_pkg::MODE_INITIAL);
      pathOut.acIdleIn <= (acSel == vcm_pkg::SLOT_NONE) || (modeEff == vcm_pkg::MODE_INITIAL);
      lineOutEnable <= (lineSel != vcm_pkg::SLOT_NONE);
      acOutEnable <= (acSel != vcm_pkg::SLOT_NONE);
      pathOut.txGain <= regGain[vcm_pkg::F_TXG_HI:vcm_pkg::F_TXG_LO];
      pathOut.rxGain <= regGain[vcm_pkg::F_RXG_HI:vcm_pkg::F_RXG_LO];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pin_reset_clears_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rstPinLvl |=> regBasic == 8'h00) else $error("basic register not cleared");
  sleep_out_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    regBasic[6] && !rstPinLvl |=> modeOut.sleep) else $error("sleep not shown");
  self_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    regBasic[5] |=> regBasic == 8'h00 && regGain == 8'h00) else $error("self reset failed");
  reserved_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    modeEff != 4'h0 |-> modeEff == 4'h2 || modeEff == 4'h5) else $error("reserved mode in force");
  settle_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    restartSettle |=> modeEff == 4'h0 [*2]) else $error("settle skipped");
  ext_codec_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    modeEff == 4'h5 |=> !modeOut.voiceCodecOn && modeOut.ansDetect) else $error("ext mode decode");
  codec_reset_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wrLane0 && regIdx == 5'h01 && wb_dat_i[6] |=> codecStateReset ##1 regCodec[6] == 1'b0)
    else $error("codec reset pulse");
  mute_pin_att_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    muteLvl |=> pathOut.rxAtten == 3'h0 && !pathOut.rxMuteFull) else $error("att with mute pin");
  slot_hiz_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    regSlot[5:3] == 3'h0 |=> !lineOutEnable && pathOut.lineIdleIn) else $error("line slot none");
  ack_one_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  // Bus answer, decode, reset, retention and settle checks; they watch internal terms so a fault
  // shows where it starts, not only at the registered outputs
  ack_timing_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    accessNew && mapped |=> wb_ack_o && !wb_err_o) else $error("mapped access not acked");
  err_unmapped_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    accessNew && !mapped |=> wb_err_o && !wb_ack_o) else $error("unmapped access not refused");
  sleep_keeps_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sleepAll && !fullReset && !wrLane0 |=> $stable(regGain) && $stable(regSlot)) else $error("sleep lost state");
  normal_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    modeEff == vcm_pkg::MODE_NORMAL |=> modeOut.toneDetect && modeOut.voiceCodecOn)
    else $error("normal mode decode");
  initial_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    modeEff == vcm_pkg::MODE_INITIAL |=> modeOut.pcmIdleAll && modeOut.memWriteOk && pathOut.lineIdleIn)
    else $error("initial mode not idle");
  ac_slot_hiz_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    acSel == vcm_pkg::SLOT_NONE |=> !acOutEnable && pathOut.acIdleIn) else $error("acoustic slot none");
  gain_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> pathOut.txGain == $past(regGain[vcm_pkg::F_TXG_HI:vcm_pkg::F_TXG_LO]) &&
    pathOut.rxGain == $past(regGain[vcm_pkg::F_RXG_HI:vcm_pkg::F_RXG_LO])) else $error("gain fields");
  dev_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fullReset |=> deviceReset && codecStateReset) else $error("full reset not shown");
  settle_early_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == vcm_pkg::VCM_SETTLE && settleCnt < 32'(SETTLE_COUNT - 1) |=> state == vcm_pkg::VCM_SETTLE)
    else $error("settle ended early");

endmodule // vcm_mode_control

`default_nettype wire

// file: rtl/vcm_pkg.sv
/*
 * Package for the voice codec mode control register bank: register indices,
 * field positions, reset values, mode codes, timing constants and carriers.
 * Assumes a 40 MHz system clock and a classic Wishbone slave with 32-bit data.
 */
package vcm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // The printed register indices are 0..3; byte address is four times the index
  localparam logic [4:0] IDX_BASIC = 5'h00;   // basic_mode_control
  localparam logic [4:0] IDX_CODEC = 5'h01;   // codec_path_control
  localparam logic [4:0] IDX_SLOT = 5'h02;    // pcm_slot_control
  localparam logic [4:0] IDX_GAIN = 5'h03;    // voice_gain_control
  localparam logic [4:0] IDX_STATUS = 5'h04;  // Read-only status of the block
  localparam int ADDR_LSB = 2;                // Word aligned registers
  localparam int ADDR_W = 7;                  // Byte address width decoded

  localparam logic [7:0] REG_RESET = 8'h00;   // All control registers clear

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_SLEEP = 6;      // whole_chip_sleep
  localparam int B_SLEEPRST = 5;   // sleep_with_reset
  localparam int F_MODE_LO = 0;    // operating_state_select low bit
  localparam int F_MODE_HI = 3;    // operating_state_select high bit
  localparam int B_ALGO = 7;       // codec_algorithm_select
  localparam int B_CRST = 6;       // codec_state_reset
  localparam int B_CSLOT = 5;      // Compressed data time slot
  localparam int B_TXSIL = 4;      // Transmit silence
  localparam int B_RXATT = 3;      // Receive attenuation enable
  localparam int F_ATT_LO = 0;     // rx_attenuation_level
  localparam int F_ATT_HI = 2;
  localparam int B_VOUT = 7;       // voice_codec_out_idle
  localparam int B_VIN = 6;        // Voice codec input idle
  localparam int F_LN_LO = 3;      // line_port_slot
  localparam int F_LN_HI = 5;
  localparam int F_AC_LO = 0;      // acoustic_port_slot
  localparam int F_AC_HI = 2;
  localparam int F_TXG_LO = 4;     // tx_voice_gain
  localparam int F_TXG_HI = 7;
  localparam int F_RXG_LO = 0;     // rx_voice_gain
  localparam int F_RXG_HI = 3;

  // ----------------------------------------------------------------
  // Modes and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_INITIAL = 4'h0;  // Initial mode
  localparam logic [3:0] MODE_NORMAL = 4'h2;   // Normal speech mode
  localparam logic [3:0] MODE_EXTEC = 4'h5;    // Extended echo canceler mode
  localparam logic [2:0] SLOT_NONE = 3'h0;     // Port not assigned
  localparam logic [2:0] ATT_MUTE = 3'h7;      // Full receive mute
  localparam logic [2:0] ATT_THRU = 3'h0;      // Pass-through
  localparam logic [3:0] GAIN_ZERO = 4'h0;     // 0 dB

  // Settle state: Gray codes along settle -> ready
  typedef enum logic [1:0] {
    VCM_SETTLE = 2'b00,
    VCM_READY = 2'b01
  } vcm_state_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40000000;         // System clock rate
  localparam int SETTLE_MS = 200;           // Settling time spent in initial mode
  localparam int SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;  // Longest time, rounded down

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] mode;        // Effective operating state
    logic sleep;             // Whole device powered down
    logic toneDetect;        // MF and call progress detector active
    logic ansDetect;         // 2100 Hz detector on both PCM inputs
    logic longEcho;          // Echo canceler covers 54 ms
    logic voiceCodecOn;      // Internal voice PCM codec active
    logic memWriteOk;        // Default parameter memory writable
    logic pcmIdleAll;        // All PCM pins carry idle pattern
  } vcm_mode_t;

  typedef struct packed {
    logic codecAdpcm32;      // 32 kbps adaptive differential coding
    logic codecSlot2;        // Compressed data in slot 2
    logic txSilence;         // Outgoing compressed data muted
    logic rxMuteFull;        // Receive path fully muted
    logic [2:0] rxAtten;     // Effective attenuation steps of 6 dB
    logic voiceOutIdle;      // Voice codec transmit pin sends idle
    logic voiceInIdle;       // Voice codec receive pin treated as idle
    logic [2:0] lineSlot;    // Line port slot, 0 = none
    logic [2:0] acSlot;      // Acoustic port slot, 0 = none
    logic lineIdleIn;        // Line input replaced by idle
    logic acIdleIn;          // Acoustic input replaced by idle
    logic [3:0] txGain;      // tx_gain_setting, 2 dB steps signed
    logic [3:0] rxGain;      // rx_gain_setting, 2 dB steps signed
  } vcm_path_t;

endpackage

// file: testbench/testbench.sv
/* Bench for the mode control bank: tests are host bus calls with expected values.
   Assumes the settle delay is shortened to SC cycles. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SC = 16; // Short settle keeps the run brief
  logic clk_sys, rst_b, pdn_b, pdr_b, mutePin, tsel, we, cyc, stb, ack, err, crst, lnEn, acEn, devRst;
  logic [3:0] sel;
  logic [31:0] adr, wdat, rdat;
  vcm_pkg::vcm_mode_t modeOut;
  vcm_pkg::vcm_path_t pathOut;
  logic [3:0] codes [3] = '{4'h1, 4'h2, 4'h5};
  int n_mismatch = 0;
  int cmp_count = 0;
  int nPulse = 0;
  vcm_mode_control #(.SETTLE_COUNT(SC)) i_vcm_mode_control (.clk_sys(clk_sys), .rst_b(rst_b), .sleepPin_b(pdn_b),
    .sleepResetPin_b(pdr_b), .mutePin(mutePin), .test_select_input(tsel), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .modeOut(modeOut), .pathOut(pathOut), .codecStateReset(crst), .lineOutEnable(lnEn), .acOutEnable(acEn),
    .deviceReset(devRst));
  vcm_host_model host (.clk_sys(clk_sys), .ack(ack), .err(err), .datIn(rdat), .cyc(cyc), .stb(stb), .we(we),
    .sel(sel), .adr(adr), .dat(wdat));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Counts codec reset pulses
  always @(posedge clk_sys) if (crst === 1'b1) nPulse++;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rd(input logic [31:0] a, exp);
    logic [31:0] q;
    logic e;
    host.acc(1'b0, a, 32'h0, q, e);
    chk(q, exp, "read");
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    logic e;
    host.acc(1'b1, a, d, q, e);
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    logic [31:0] q;
    logic e;
    int p0;
    {rst_b, pdn_b, pdr_b, mutePin, tsel} = 5'b01100;
    tick(4);
    rst_b <= 1'b1;
    tick(SC + 4);
    for (int i = 0; i < 4; i++) rd(32'(i * 4), 32'h0);
    rd(32'h10, 32'h20);
    chk({modeOut.memWriteOk, modeOut.pcmIdleAll, lnEn}, 3'b110, "init");
    $display("test reset done");
    foreach (codes[k]) begin
      tsel <= (codes[k] == 4'h5);
      wr(32'h0, {28'h0, codes[k]});
      tick(SC + 4);
      chk(modeOut.mode, (codes[k] == 4'h1) ? 4'h0 : codes[k], "mode");
      chk(modeOut.toneDetect, codes[k] == 4'h2 || codes[k] == 4'h5, "tone");
      chk({modeOut.ansDetect, modeOut.longEcho}, {2{codes[k] == 4'h5}}, "ext");
    end
    chk({modeOut.voiceCodecOn, modeOut.memWriteOk}, 2'b00, "ext codec");
    $display("test modes done");
    wr(32'h4, 32'h3B);
    wr(32'h8, 32'hC8);
    wr(32'hC, 32'h8F);
    rd(32'h4, 32'h3B);
    rd(32'h8, 32'hC8);
    rd(32'hC, 32'h8F);
    chk({pathOut.codecAdpcm32, pathOut.codecSlot2, pathOut.txSilence, pathOut.rxAtten}, 6'h3B, "cp");
    chk({pathOut.voiceOutIdle, pathOut.voiceInIdle, pathOut.lineSlot, pathOut.acSlot}, 8'hC8, "sl");
    chk({lnEn, acEn, pathOut.lineIdleIn, pathOut.acIdleIn}, 4'b1001, "idle");
    chk({pathOut.txGain, pathOut.rxGain}, 8'h8F, "gain");
    mutePin <= 1'b1;
    tick(8);
    chk(pathOut.rxAtten, 3'h0, "mute");
    mutePin <= 1'b0;
    wr(32'h4, 32'h0F);
    tick(8);
    chk({pathOut.rxMuteFull, pathOut.txSilence}, 2'b10, "full");
    p0 = nPulse;
    wr(32'h4, 32'h40);
    tick(3);
    chk(nPulse - p0, 1, "crst");
    rd(32'h4, 32'h0);
    host.acc(1'b1, 32'h40, 32'hFF, q, e);
    chk(e, 1'b1, "unmapped");
    $display("test paths done");
    pdn_b <= 1'b0;
    tick(8);
    chk(modeOut.sleep, 1'b1, "pin sleep");
    pdn_b <= 1'b1;
    tsel <= 1'b0;
    wr(32'h0, 32'h42);
    tick(SC + 4);
    chk({modeOut.sleep, modeOut.mode}, 5'h10, "sleep");
    rd(32'hC, 32'h8F);
    wr(32'h0, 32'h25);
    tick(4);
    rd(32'h0, 32'h0);
    rd(32'hC, 32'h0);
    wr(32'hC, 32'h5A);
    pdr_b <= 1'b0;
    tick(10);
    chk(devRst, 1'b1, "pin reset");
    pdr_b <= 1'b1;
    tick(SC + 4);
    rd(32'hC, 32'h0);
    $display("test resets done");
    final_report;
  end
  // Watchdog well beyond the expected run
  initial begin
    #500000;
    n_mismatch++;
    final_report;
  end
endmodule // testbench
`default_nettype wire

// file: testbench/vcm_host_model.sv
/* Host controller model: a classic Wishbone master for the control registers.
   Assumes a slave that answers every request with ack or err. */
`timescale 1ns/1ps
`default_nettype none
module vcm_host_model (
  input wire logic clk_sys,      // System clock
  input wire logic ack,          // Slave acknowledge
  input wire logic err,          // Slave error
  input wire logic [31:0] datIn, // Read data
  output logic cyc,              // Bus cycle
  output logic stb,              // Strobe
  output logic we,               // Write enable
  output logic [3:0] sel,        // Byte selects
  output logic [31:0] adr,       // Address
  output logic [31:0] dat        // Write data
);
  // Idle bus from time zero
  initial {cyc, stb, we, sel, adr, dat} = '0;
  // One cycle, entered just after an edge; held until ack or err; only the bench watchdog ends a lost answer
  task automatic acc(input logic w, input logic [31:0] a, d, output logic [31:0] q, output logic e);
    {cyc, stb, we, sel, adr, dat} <= {1'b1, 1'b1, w, 4'hF, a, d};
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = datIn;
    e = (err === 1'b1);
    {cyc, stb, we} <= 3'b000;
    @(posedge clk_sys); // One idle cycle before the next request
  endtask
endmodule // vcm_host_model
`default_nettype wire
